// >>> verilog/gw_status_pkg.sv
/*
  package: constants, field positions, register offsets and states of the
  gateway input-status block.
  assumes: one clock domain, plain register port, byte-wide status image.
*/
package gw_status_pkg;
  // register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_STATUS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_LENGTH_COUNT = 4'h1;
  localparam logic [3:0] OFS_CONTROL = 4'h2;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h3;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h4;
  localparam logic [3:0] OFS_BUF_LEVEL_LO = 4'h5;
  localparam logic [3:0] OFS_BUF_LEVEL_HI = 4'h6;
  localparam logic [3:0] OFS_FRAME_LEN = 4'h7;
  // status byte 0 fields
  localparam int BIT_BLOCK_READY = 4;
  localparam int BIT_DATA_LOSS = 5;
  localparam int BIT_OVERFLOW = 6;
  localparam int BIT_NEW_DATA = 7;
  // control register fields
  localparam int BIT_GATHERED_MODE = 0;
  localparam int BIT_LOSS_RESET = 1;
  // interrupt status fields
  localparam int IRQ_BLOCK = 0;
  localparam int IRQ_LOSS = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_NEWSET = 3;
  localparam int IRQ_W = 4;
  // buffer: 1 kByte shared storage
  localparam int BUF_BYTES = 1024;
  localparam int LEVEL_W = 11;
  localparam logic [10:0] BUF_CAP = 11'h400;
  // reset values
  localparam logic [7:0] RST_LENGTH = 8'h00;
  localparam logic [7:0] RST_FRAME_LEN = 8'h08;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [3:0] RST_MASK = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SET = 3'b010,
    ST_DONE = 3'b100
  } set_state_e;
endpackage : gw_status_pkg

// >>> verilog/sticky_bit.sv
/*
  sticky_bit: one flag set by a hardware event and cleared by a clear
  request; a set in the clear cycle wins.
  assumes: synchronous active-low reset on the shared clock.
*/
`timescale 1ns/10ps
module sticky_bit (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic set_in,
  input wire logic clr_in,
  // state
  output logic flag_out
);
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      flag_out <= 1'b0;
    else if (set_in)
      flag_out <= 1'b1;
    else if (clr_in)
      flag_out <= 1'b0;
  end
endmodule : sticky_bit

// >>> verilog/gw_input_status.sv
/*
  gw_input_status: builds the two status bytes placed ahead of user data in
  the input image, tracks the shared 1 kByte buffer level and holds off the
  serial rts handshake while that buffer has overflowed in gathered mode.
  assumes: one clock, synchronous inputs, a data-set producer that offers
  each set with its length on a one-cycle strobe, and buffer push/pop
  strobes of one byte each.
*/
// Strobed register access and the address map were left to the implementer.
// Contract
// - gathered mode: toggle block ready per buffer block
// - data loss sticks until reset function clears
// - oversize set truncated to frame, loss set
// - gathered mode: overflow flag on buffer overflow
// - overflow clears itself when space returns
// - rts held inactive while overflow set
// - 1 kByte shared buffer sets overflow limit
// - transparent mode: toggle new data per set
// - status byte 1 holds user byte count
// - length counts 1..ff, zero after reset
// - toggle bits flip on each event
`timescale 1ns/10ps
module gw_input_status (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [gw_status_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // data sets toward the plc
  input wire logic set_valid_in,
  input wire logic [9:0] set_len_in,
  input wire logic set_from_buffer_in,
  input wire logic lost_in,
  // shared buffer traffic
  input wire logic buf_push_in,
  input wire logic buf_pop_in,
  // input image status bytes
  output logic [7:0] status_byte0_out,
  output logic [7:0] status_byte1_out,
  output logic image_update_out,
  // serial handshake and interrupt
  output logic rts_out,
  output logic irq_out
);
  import gw_status_pkg::*;

  logic [7:0] control_r;
  logic [7:0] frame_len_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic block_ready_toggle_r;
  logic new_data_toggle_r;
  logic overflow_flag_r;
  logic data_loss_flag;
  logic [7:0] payload_length_code_r;
  logic [LEVEL_W-1:0] level_r;
  logic [LEVEL_W-1:0] level_nxt;
  logic [9:0] pend_len_r;
  logic pend_buf_r;
  logic pend_trunc_r;
  set_state_e state_r;
  logic gathered;
  logic loss_clear;
  logic push_ok;
  logic pop_ok;
  logic overflow_event;
  logic trunc_event;
  logic irq_rd_clear;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_status;
  logic [7:0] read_mux;
  logic [9:0] send_len;

  assign gathered = control_r[BIT_GATHERED_MODE];
  // writing the loss-reset bit acts as the device reset function
  assign loss_clear = reg_wr_in && (reg_addr_in == OFS_CONTROL)
    && reg_wdata_in[BIT_LOSS_RESET];
  assign irq_rd_clear = reg_rd_in && (reg_addr_in == OFS_IRQ_STATUS);

  // control registers
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      control_r <= RST_CONTROL;
      frame_len_r <= RST_FRAME_LEN;
      irq_mask_r <= RST_MASK;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == OFS_CONTROL)
        control_r <= {7'h00, reg_wdata_in[BIT_GATHERED_MODE]};
      else if (reg_addr_in == OFS_IRQ_MASK)
        irq_mask_r <= reg_wdata_in[IRQ_W-1:0];
      else if (reg_addr_in == OFS_FRAME_LEN)
        frame_len_r <= reg_wdata_in;
    end
  end

  // buffer occupancy; pushes beyond capacity are dropped
  assign push_ok = buf_push_in && (level_r != BUF_CAP);
  assign pop_ok = buf_pop_in && (level_r != '0);
  assign overflow_event = buf_push_in && (level_r == BUF_CAP)
    && !buf_pop_in;

  always_comb
  begin
    level_nxt = level_r;
    if (push_ok && !pop_ok)
      level_nxt = level_r + 11'h001;
    else if (pop_ok && !push_ok)
      level_nxt = level_r - 11'h001;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      level_r <= '0;
    else
      level_r <= level_nxt;
  end

  // overflow flag: set in gathered mode on a refused push with no pop in the same cycle, self-clearing once space returns
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      overflow_flag_r <= 1'b0;
    else if (gathered && overflow_event)
      overflow_flag_r <= 1'b1;
    else if (level_nxt < BUF_CAP)
      overflow_flag_r <= 1'b0;
  end

  // rts active high; withdrawn only while the overflow flag is set, not when merely full
  assign rts_out = !overflow_flag_r;

  // data-set handling: a set is truncated, latched, then published
  assign trunc_event = set_valid_in && (state_r == ST_IDLE)
    && (set_len_in > {2'b00, frame_len_r});
  assign send_len = (set_len_in > {2'b00, frame_len_r})
    ? {2'b00, frame_len_r} : set_len_in;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= ST_IDLE;
      pend_len_r <= '0;
      pend_buf_r <= 1'b0;
      pend_trunc_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (set_valid_in)
          begin
            pend_len_r <= send_len;
            pend_buf_r <= set_from_buffer_in;
            pend_trunc_r <= trunc_event;
            state_r <= ST_SET;
          end
        end
        ST_SET:
          state_r <= ST_DONE;
        ST_DONE:
          state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // length code and toggles move in ST_SET; status bytes follow one edge on
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      payload_length_code_r <= RST_LENGTH;
    else if (state_r == ST_SET)
      payload_length_code_r <= pend_len_r[7:0];
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      block_ready_toggle_r <= 1'b0;
    else if (state_r == ST_SET && gathered && pend_buf_r)
      block_ready_toggle_r <= !block_ready_toggle_r;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      new_data_toggle_r <= 1'b0;
    else if (state_r == ST_SET && !gathered)
      new_data_toggle_r <= !new_data_toggle_r;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      image_update_out <= 1'b0;
    else
      image_update_out <= (state_r == ST_DONE);
  end

  // data loss: lost set, truncation or refused set; held until reset fn
  sticky_bit loss_bit (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .set_in(lost_in || trunc_event
      || (set_valid_in && state_r != ST_IDLE)),
    .clr_in(loss_clear),
    .flag_out(data_loss_flag)
  );

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      status_byte0_out <= 8'h00;
      status_byte1_out <= 8'h00;
    end
    else
    begin
      status_byte0_out <= {new_data_toggle_r, overflow_flag_r,
        data_loss_flag, block_ready_toggle_r, 4'h0};
      status_byte1_out <= payload_length_code_r;
    end
  end

  // interrupt events, cleared by a read of the status register
  assign irq_set[IRQ_BLOCK] = state_r == ST_SET && gathered && pend_buf_r;
  assign irq_set[IRQ_LOSS] = lost_in || trunc_event;
  assign irq_set[IRQ_OVF] = gathered && overflow_event;
  assign irq_set[IRQ_NEWSET] = state_r == ST_SET && !gathered;

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi = gi + 1)
    begin : g_irq
      sticky_bit irq_bit (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .set_in(irq_set[gi]),
        .clr_in(irq_rd_clear),
        .flag_out(irq_status[gi])
      );
    end
  endgenerate

  assign irq_out = |(irq_status & irq_mask_r);

  // register read
  always_comb
  begin
    if (reg_addr_in == OFS_STATUS_FLAGS)
      read_mux = {new_data_toggle_r, overflow_flag_r, data_loss_flag,
        block_ready_toggle_r, 4'h0};
    else if (reg_addr_in == OFS_LENGTH_COUNT)
      read_mux = payload_length_code_r;
    else if (reg_addr_in == OFS_CONTROL)
      read_mux = control_r;
    else if (reg_addr_in == OFS_IRQ_STATUS)
      read_mux = {4'h0, irq_status};
    else if (reg_addr_in == OFS_IRQ_MASK)
      read_mux = {4'h0, irq_mask_r};
    else if (reg_addr_in == OFS_BUF_LEVEL_LO)
      read_mux = level_r[7:0];
    else if (reg_addr_in == OFS_BUF_LEVEL_HI)
      read_mux = {5'h00, level_r[10:8]};
    else if (reg_addr_in == OFS_FRAME_LEN)
      read_mux = frame_len_r;
    else
      read_mux = 8'h00;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      reg_rdata_out <= read_mux;
    else
      reg_rdata_out <= 8'h00;
  end
endmodule : gw_input_status

// >>> test/gw_plc_master.sv
/*
  gw_plc_master: fieldbus master taking the input image after each update.
  assumes: image_update_in is a one-cycle pulse with the status bytes.
*/
`timescale 1ns/10ps
module gw_plc_master (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // input image from the gateway
  input wire logic image_update_in,
  input wire logic [7:0] status_byte0_in,
  input wire logic [7:0] status_byte1_in,
  // what the master took
  output logic fresh_block_out,
  output logic [7:0] taken_len_out
);
  logic ready_seen_r;
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      ready_seen_r <= 1'h0;
      fresh_block_out <= 1'h0;
      taken_len_out <= 8'h00;
    end
    else
    begin
      // a flip of the ready bit means the counted bytes are buffered data
      fresh_block_out <= image_update_in &&
        (status_byte0_in[4] != ready_seen_r);
      if (image_update_in)
      begin
        ready_seen_r <= status_byte0_in[4];
        taken_len_out <= status_byte1_in;
      end
    end
  end
endmodule : gw_plc_master

// >>> test/gw_input_status_properties.sv
/*
  gw_input_status_checker: port-level checks of the status block.
  assumes: bound onto gw_input_status, one clock, sync active-low reset.
*/
`timescale 1ns/10ps
module gw_input_status_checker (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // stimulus seen
  input wire logic set_valid_in,
  input wire logic set_from_buffer_in,
  input wire logic buf_push_in,
  input wire logic buf_pop_in,
  // outputs watched
  input wire logic [7:0] status_byte0_out,
  input wire logic [7:0] status_byte1_out,
  input wire logic image_update_out,
  input wire logic rts_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence set_taken;
    set_valid_in ##3 image_update_out;
  endsequence
  // overflow lands on the edge that samples the strobe; the second cycle back is slack
  sequence recent_push;
    $past(buf_push_in) || $past(buf_push_in, 2);
  endsequence
  sequence recent_pop;
    $past(buf_pop_in) || $past(buf_pop_in, 2);
  endsequence
  update_cause_a: assert property (image_update_out |-> $past(set_valid_in, 3))
    else $error("image update without a set");
  length_moves_a: assert property ($changed(status_byte1_out) |-> image_update_out)
    else $error("length changed outside update");
  ready_hold_a: assert property (image_update_out && !$past(set_from_buffer_in, 3)
    |-> $stable(status_byte0_out[4]))
    else $error("block ready flipped without buffer data");
  toggle_quiet_a: assert property (!image_update_out |->
    $stable(status_byte0_out[4]) && $stable(status_byte0_out[7]))
    else $error("toggle moved between updates");
  one_toggle_a: assert property (image_update_out |->
    !($changed(status_byte0_out[4]) && $changed(status_byte0_out[7])))
    else $error("both toggles flipped together");
  rts_drop_a: assert property ($fell(rts_out) |-> recent_push)
    else $error("rts dropped without a push");
  rts_return_a: assert property ($rose(rts_out) |-> recent_pop)
    else $error("rts returned without a pop");
  overflow_shown_a: assert property (!rts_out && !$past(rts_out, 3)
    && image_update_out |-> status_byte0_out[6])
    else $error("overflow not shown in status");
  length_reset_a: assert property ($rose(rst_n_in) |-> status_byte1_out == 8'h00)
    else $error("length not zero after reset");
  set_seen_c: cover property (set_taken);
endmodule : gw_input_status_checker

// >>> test/gw_input_status_test.sv
/*
  gw_input_status_test: register, data-set and buffer scenarios.
  assumes: design package, master model and checker compiled first.
*/
`timescale 1ns/10ps
module gw_input_status_test;
  import gw_status_pkg::*;
  logic ref_clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic [ADDR_W-1:0] reg_addr_in = '0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'h0, reg_rd_in = 1'h0, lost_in = 1'h0;
  logic set_valid_in = 1'h0, set_from_buffer_in = 1'h0;
  logic [9:0] set_len_in = 10'h000;
  logic buf_push_in = 1'h0, buf_pop_in = 1'h0;
  logic [7:0] reg_rdata_out, status_byte0_out, status_byte1_out, taken;
  logic image_update_out, rts_out, irq_out, fresh;
  int fails = 0;
  int comparisons = 0;
  int n;
  always #5 ref_clk_in = ~ref_clk_in;
  gw_input_status dut (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .set_valid_in, .set_len_in,
    .set_from_buffer_in, .lost_in, .buf_push_in, .buf_pop_in,
    .status_byte0_out, .status_byte1_out, .image_update_out, .rts_out,
    .irq_out);
  gw_plc_master plc (.ref_clk_in, .rst_n_in,
    .image_update_in(image_update_out), .status_byte0_in(status_byte0_out),
    .status_byte1_in(status_byte1_out), .fresh_block_out(fresh),
    .taken_len_out(taken));
  task automatic tally_and_finish();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'h0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e,
    input logic [7:0] m = 8'hff);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'h1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'h0;
    #1 chk(reg_rdata_out & m, e);
  endtask : rd
  // offer a set, then wait for its image update under a bound
  task automatic sset(input logic [9:0] len, input logic fb);
    @(posedge ref_clk_in);
    set_valid_in <= 1'h1;
    set_len_in <= len;
    set_from_buffer_in <= fb;
    @(posedge ref_clk_in);
    set_valid_in <= 1'h0;
    n = 0;
    while (image_update_out !== 1'h1 && n < 8)
    begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    if (n == 8)
    begin
      fails++;
      tally_and_finish();
    end
  endtask : sset
  initial
  begin
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1'h1;
    rd(OFS_STATUS_FLAGS, 8'h00);
    rd(OFS_LENGTH_COUNT, RST_LENGTH);
    rd(OFS_FRAME_LEN, RST_FRAME_LEN);
    rd(OFS_IRQ_MASK, {4'h0, RST_MASK});
    rd(4'hf, 8'h00);
    chk({7'h00, rts_out}, 8'h01);
    sset(10'h005, 1'h0);
    chk(status_byte1_out, 8'h05);
    chk(status_byte0_out, 8'h80);
    sset(10'h005, 1'h0);
    chk(status_byte0_out, 8'h00);
    rd(OFS_LENGTH_COUNT, 8'h05);
    sset(10'h014, 1'h0);
    chk(status_byte1_out, RST_FRAME_LEN);
    chk(status_byte0_out, 8'ha0);
    sset(10'h003, 1'h0);
    chk(status_byte0_out, 8'h20);
    wr(OFS_CONTROL, 8'h02);
    sset(10'h008, 1'h0);
    chk(status_byte0_out, 8'h80);
    @(posedge ref_clk_in);
    lost_in <= 1'h1;
    @(posedge ref_clk_in);
    lost_in <= 1'h0;
    sset(10'h001, 1'h0);
    chk(status_byte0_out, 8'h20);
    wr(OFS_FRAME_LEN, 8'hff);
    wr(OFS_CONTROL, 8'h02);
    sset(10'h0ff, 1'h0);
    chk(status_byte1_out, 8'hff);
    chk(status_byte0_out, 8'h80);
    chk({7'h00, irq_out}, 8'h00);
    rd(OFS_IRQ_STATUS, 8'h0a);
    wr(OFS_IRQ_MASK, 8'h01);
    wr(OFS_CONTROL, 8'h01);
    sset(10'h004, 1'h1);
    chk(status_byte0_out, 8'h90);
    @(posedge ref_clk_in);
    #1 chk({7'h00, fresh}, 8'h01);
    chk(taken, 8'h04);
    chk({7'h00, irq_out}, 8'h01);
    rd(OFS_IRQ_STATUS, 8'h01, 8'h01);
    chk({7'h00, irq_out}, 8'h00);
    sset(10'h004, 1'h0);
    chk(status_byte0_out, 8'h90);
    // fill the shared buffer to exactly its capacity
    @(posedge ref_clk_in);
    buf_push_in <= 1'h1;
    repeat (1024) @(posedge ref_clk_in);
    buf_push_in <= 1'h0;
    rd(OFS_BUF_LEVEL_HI, 8'h04);
    rd(OFS_BUF_LEVEL_LO, 8'h00);
    chk({7'h00, rts_out}, 8'h01);
    @(posedge ref_clk_in);
    buf_push_in <= 1'h1;
    @(posedge ref_clk_in);
    buf_push_in <= 1'h0;
    repeat (2) @(posedge ref_clk_in);
    #1 chk({7'h00, rts_out}, 8'h00);
    sset(10'h002, 1'h1);
    chk(status_byte0_out, 8'hc0);
    @(posedge ref_clk_in);
    buf_pop_in <= 1'h1;
    @(posedge ref_clk_in);
    buf_pop_in <= 1'h0;
    repeat (2) @(posedge ref_clk_in);
    #1 chk({7'h00, rts_out}, 8'h01);
    tally_and_finish();
  end
endmodule : gw_input_status_test
bind gw_input_status gw_input_status_checker chk (.ref_clk_in, .rst_n_in,
  .set_valid_in, .set_from_buffer_in, .buf_push_in, .buf_pop_in,
  .status_byte0_out, .status_byte1_out, .image_update_out, .rts_out);
